// >>> twr_regs.svh
// Shared constants for the two-wire responder and its bus controller.
`ifndef TWR_REGS_SVH
`define TWR_REGS_SVH
// Default 8-bit address byte for writes; a read adds the low bit.
`define TWR_ADDR_W 8'h10
`define TWR_RD_BIT 8'h01
// Check byte generator x^8 + x^2 + x + 1 and its starting remainder.
`define TWR_CRC_POLY 8'h07
`define TWR_CRC_INIT 8'h00
// Bit count at which a byte is complete, and the timer width.
`define TWR_BYTE_END 4'h8
`define TWR_TMR_W 28
// Clock rates in hertz.
`define TWR_SYS_HZ 100000000
`define TWR_STD_HZ 100000
`define TWR_FAST_HZ 400000
`define TWR_CYC_PER_MS (`TWR_SYS_HZ / 1000)
// Timeouts in milliseconds; the clock-low limits sit inside their windows.
`define TWR_TO_STD_MS 30
`define TWR_TO_FAST_MS 10
`define TWR_EXT_CTRL_MS 10
`define TWR_EXT_RESP_MS 25
`define TWR_LONG_MS 2000
// Quarter bit periods of the controller, rounded up so the rate never exceeds the setting.
`define TWR_QTR_STD_CYC ((`TWR_SYS_HZ + 4 * `TWR_STD_HZ - 1) / (4 * `TWR_STD_HZ))
`define TWR_QTR_FAST_CYC ((`TWR_SYS_HZ + 4 * `TWR_FAST_HZ - 1) / (4 * `TWR_FAST_HZ))
`endif

// >>> twr_pkg.sv
// Types and the check-byte function shared by both ends of the two-wire link.
`default_nettype none
`include "twr_regs.svh"
package twr_pkg;
  // Responder bit engine states.
  typedef enum logic [4:0] {
    D_IDLE = 5'h01, D_RX = 5'h02, D_RXACK = 5'h04, D_TX = 5'h08, D_TXACK = 5'h10
  } twr_dstate_t;
  // Controller sequencer states.
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_START = 4'h2, H_BIT = 4'h4, H_STOP = 4'h8
  } twr_hstate_t;
  // Meaning of the byte being moved: address, register, write data or check, read data or check.
  typedef enum logic [5:0] {
    K_AD = 6'h01, K_RA = 6'h02, K_WD = 6'h04, K_WC = 6'h08, K_RD = 6'h10, K_RC = 6'h20
  } twr_kind_t;

  // One byte folded into the running check byte, most significant bit first.
  function automatic logic [7:0] twr_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `TWR_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : twr_crc8
endpackage : twr_pkg
`default_nettype wire

// >>> twr_if.sv
// Open-drain two-wire bus joining the controller and the responder.
`timescale 1ns/1ps
`default_nettype none
interface twr_if;
  logic h_scl_o;
  logic h_scl_oe_n;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic scl;
  logic sda;
  // A released line floats high through the pull-up; any driver wins low.
  assign scl = h_scl_oe_n | h_scl_o;
  assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
  modport ctl (output h_scl_o, output h_scl_oe_n, output h_sda_o, output h_sda_oe_n, input sda);
  modport dev (output d_sda_o, output d_sda_oe_n, input scl, input sda);
endinterface : twr_if
`default_nettype wire

// >>> twr_responder.sv
// Two-wire responder with check bytes, address auto-increment and clock-low timeouts.
`timescale 1ns/1ps
`default_nettype none
`include "twr_regs.svh"
module twr_responder
  import twr_pkg::*;
#(
  parameter int unsigned TO_STD_CYC = `TWR_TO_STD_MS * `TWR_CYC_PER_MS,
  parameter int unsigned TO_FAST_CYC = `TWR_TO_FAST_MS * `TWR_CYC_PER_MS,
  parameter int unsigned EXT_CTRL_CYC = `TWR_EXT_CTRL_MS * `TWR_CYC_PER_MS,
  parameter int unsigned EXT_RESP_CYC = `TWR_EXT_RESP_MS * `TWR_CYC_PER_MS,
  parameter int unsigned TO_LONG_CYC = `TWR_LONG_MS * `TWR_CYC_PER_MS
) (
  input wire logic sys_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; all state holds while low.
  twr_if.dev bus, // Two-wire bus pins.
  output logic [7:0] reg_addr, // Register pointer into the device space.
  output logic [7:0] reg_wdata, // Data for a register write.
  output logic reg_we, // Register write strobe.
  output logic reg_re, // Register read strobe.
  input wire logic [7:0] reg_rdata, // Read data, valid the cycle after reg_re.
  input wire logic cfg_addr_valid, // Use cfg_addr instead of the default address.
  input wire logic [6:0] cfg_addr, // Configured seven-bit responder address.
  input wire logic cfg_fast, // Speed setting: 1 fast, 0 standard.
  input wire logic cfg_crc_en, // Check bytes in use.
  input wire logic cfg_timeout_en, // Programmable timeouts in use.
  input wire logic cfg_update_mode, // Settings-edit mode active.
  input wire logic switch_to_two_wire_cmd, // Pulse: make this the host interface.
  input wire logic other_if_cmd, // Pulse: another host interface was chosen.
  output logic two_wire_active, // This interface is the active one.
  output logic speed_fast, // Speed in effect.
  output logic if_reset // High while a timeout holds the interface in reset.
);

  typedef struct packed {
    twr_dstate_t st;
    twr_kind_t kind;
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] rbuf;
    logic [7:0] wbuf;
    logic [7:0] ptr;
    logic [7:0] crc;
    logic ack;
    logic oe_n;
    logic we;
    logic re;
    logic cap;
    logic fast;
    logic upd_q;
    logic tw_on;
    logic tor;
    logic [`TWR_TMR_W-1:0] low_cnt;
    logic [`TWR_TMR_W-1:0] ext_cnt;
  } twr_dev_t;

  localparam twr_dev_t DEV_RST = '{
    st: D_IDLE, kind: K_AD, scl1: 1'b1, scl2: 1'b1, scl3: 1'b1,
    sda1: 1'b1, sda2: 1'b1, sda3: 1'b1, oe_n: 1'b1, fast: 1'b1,
    tw_on: 1'b1, crc: `TWR_CRC_INIT, default: '0
  };

  twr_dev_t s;
  twr_dev_t n;
  logic [7:0] addr_w;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic trip;

  // Starts a transmitted byte: the first bit goes out on the falling edge that calls this.
  function automatic twr_dev_t dev_send(input twr_dev_t x, input logic [7:0] b);
    twr_dev_t y;
    y = x;
    y.st = D_TX;
    y.oe_n = b[7];
    y.tx = {b[6:0], 1'b0};
    y.cnt = 4'h1;
    return y;
  endfunction : dev_send

  // Address byte in use and bus events seen through the synchronisers.
  assign addr_w = cfg_addr_valid ? {cfg_addr, 1'b0} : `TWR_ADDR_W;
  assign rise = s.scl2 & ~s.scl3;
  assign fall = ~s.scl2 & s.scl3;
  assign start = s.scl2 & s.scl3 & s.sda3 & ~s.sda2;
  assign stop = s.scl2 & s.scl3 & ~s.sda3 & s.sda2;

  // Timeout decision. This end never holds the clock low, so its own stretch total
  // stays at zero and trips only when EXT_RESP_CYC is zero; otherwise only the controller's cumulative low time can trip here.
  always_comb begin
    trip = 32'(s.low_cnt) >= TO_LONG_CYC;
    if (cfg_timeout_en) begin
      if (s.fast) begin
        trip = trip | (32'(s.low_cnt) >= TO_FAST_CYC);
      end else begin
        trip = trip | (32'(s.low_cnt) >= TO_STD_CYC);
        trip = trip | (32'(s.ext_cnt) >= EXT_CTRL_CYC) | (EXT_RESP_CYC == 0);
      end
    end
  end

  // Next-state logic for the whole responder.
  always_comb begin
    n = s;
    n.we = 1'b0;
    n.re = 1'b0;
    n.tor = 1'b0;
    n.cap = s.re;
    n.scl1 = bus.scl;
    n.scl2 = s.scl1;
    n.scl3 = s.scl2;
    n.sda1 = bus.sda;
    n.sda2 = s.sda1;
    n.sda3 = s.sda2;
    if (s.cap) begin
      n.rbuf = reg_rdata;
    end
    // Each write advances the pointer once the strobe has been seen.
    if (s.we) begin
      n.ptr = s.ptr + 8'h01;
    end
    // A new speed only takes hold as settings-edit mode ends.
    n.upd_q = cfg_update_mode;
    if (s.upd_q && !cfg_update_mode) begin
      n.fast = cfg_fast;
    end
    if (switch_to_two_wire_cmd) begin
      n.tw_on = 1'b1;
    end else if (other_if_cmd) begin
      n.tw_on = 1'b0;
    end
    // Clock-low timers saturate so they cannot wrap: the phase count at the long limit, the total at EXT_CTRL_CYC.
    if (s.scl2) begin
      n.low_cnt = '0;
    end else if (32'(s.low_cnt) < TO_LONG_CYC) begin
      n.low_cnt = s.low_cnt + 1'b1;
    end
    if (start || stop || s.st == D_IDLE) begin
      n.ext_cnt = '0;
    end else if (!s.scl2 && 32'(s.ext_cnt) < EXT_CTRL_CYC) begin
      n.ext_cnt = s.ext_cnt + 1'b1;
    end
    if (!s.tw_on || trip) begin
      n.st = D_IDLE;
      n.oe_n = 1'b1;
      n.crc = `TWR_CRC_INIT;
      n.tor = trip;
    end else if (start) begin
      // A repeated start keeps the running check byte; after a stop it is already clear.
      n.st = D_RX;
      n.kind = K_AD;
      n.cnt = '0;
      n.oe_n = 1'b1;
    end else if (stop) begin
      n.st = D_IDLE;
      n.oe_n = 1'b1;
      n.crc = `TWR_CRC_INIT;
    end else begin
      unique case (s.st)
        D_IDLE: begin
        end
        D_RX: begin
          if (rise) begin
            n.sh = {s.sh[6:0], s.sda2};
            n.cnt = s.cnt + 4'h1;
          end else if (fall && s.cnt == `TWR_BYTE_END) begin
            n.st = D_RXACK;
            n.oe_n = 1'b0;
            unique case (s.kind)
              K_AD: begin
                n.crc = twr_crc8(s.crc, s.sh);
                if (s.sh[7:1] != addr_w[7:1]) begin
                  n.st = D_IDLE;
                  n.oe_n = 1'b1;
                end else if (s.sh[0]) begin
                  n.re = 1'b1;
                end
              end
              K_RA: begin
                n.ptr = s.sh;
                n.crc = twr_crc8(s.crc, s.sh);
              end
              K_WD: begin
                n.wbuf = s.sh;
                n.crc = twr_crc8(s.crc, s.sh);
                n.we = !cfg_crc_en;
              end
              K_WC: begin
                // Data is written only once its check byte matches.
                if (s.sh == s.crc) begin
                  n.we = 1'b1;
                  n.crc = `TWR_CRC_INIT;
                end else begin
                  n.st = D_IDLE;
                  n.oe_n = 1'b1;
                  n.crc = `TWR_CRC_INIT;
                end
              end
              default: begin
              end
            endcase
          end
        end
        D_RXACK: begin
          if (fall) begin
            n.oe_n = 1'b1;
            n.cnt = '0;
            n.st = D_RX;
            if (s.kind == K_AD && s.sh[0]) begin
              n = dev_send(n, s.rbuf);
              n.kind = K_RD;
              n.crc = twr_crc8(s.crc, s.rbuf);
            end else if (s.kind == K_AD) begin
              n.kind = K_RA;
            end else if (s.kind == K_WD && cfg_crc_en) begin
              n.kind = K_WC;
            end else begin
              n.kind = K_WD;
            end
          end
        end
        D_TX: begin
          if (fall) begin
            if (s.cnt == `TWR_BYTE_END) begin
              n.oe_n = 1'b1;
              n.st = D_TXACK;
              if (s.kind == K_RD) begin
                n.ptr = s.ptr + 8'h01;
                n.re = 1'b1;
              end
            end else begin
              n.oe_n = s.tx[7];
              n.tx = {s.tx[6:0], 1'b0};
              n.cnt = s.cnt + 4'h1;
            end
          end
        end
        D_TXACK: begin
          if (rise) begin
            n.ack = ~s.sda2;
          end else if (fall) begin
            if (!s.ack) begin
              // Refusal ends the read: last byte or a bad check byte.
              n.st = D_IDLE;
              n.crc = `TWR_CRC_INIT;
            end else if (s.kind == K_RD && cfg_crc_en) begin
              n = dev_send(n, s.crc);
              n.kind = K_RC;
              n.crc = `TWR_CRC_INIT;
            end else begin
              n = dev_send(n, s.rbuf);
              n.kind = K_RD;
              n.crc = twr_crc8(s.crc, s.rbuf);
            end
          end
        end
      endcase
    end
  end

  // State register; the clock enable freezes everything including the synchronisers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s <= DEV_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  // Outputs straight from state.
  assign reg_addr = s.ptr;
  assign reg_wdata = s.wbuf;
  assign reg_we = s.we;
  assign reg_re = s.re;
  assign two_wire_active = s.tw_on;
  assign speed_fast = s.fast;
  assign if_reset = s.tor;
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe_n = s.oe_n;

endmodule : twr_responder
`default_nettype wire

// >>> twr_controller.sv
// Two-wire bus controller that issues register reads and writes with optional check bytes.
`timescale 1ns/1ps
`default_nettype none
`include "twr_regs.svh"
module twr_controller
  import twr_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; all state holds while low.
  twr_if.ctl bus, // Two-wire bus pins.
  input wire logic go, // Pulse: start a transfer when idle.
  input wire logic rd, // Transfer is a read.
  input wire logic [6:0] dev_addr, // Responder address.
  input wire logic [7:0] reg_sel, // First register of the transfer.
  input wire logic [3:0] len, // Data bytes, one or more.
  input wire logic rs, // Read uses a repeated start, else stop then start.
  input wire logic crc_en, // Check bytes in use.
  input wire logic fast, // 1 for 400 kHz, 0 for 100 kHz.
  input wire logic [7:0] wr_data, // Next byte to write.
  output logic wr_take, // Pulse: wr_data taken.
  output logic [7:0] rd_data, // Byte read.
  output logic rd_valid, // Pulse: rd_data new.
  output logic busy, // Transfer in progress.
  output logic done, // Pulse: transfer finished.
  output logic err // Refusal or bad check byte in the last transfer.
);

  typedef struct packed {
    twr_hstate_t st;
    twr_kind_t kind;
    logic [1:0] ph;
    logic [7:0] div;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] crc;
    logic [3:0] left;
    logic rdph;
    logic restart;
    logic scl_oe_n;
    logic sda_oe_n;
    logic sda1;
    logic sda2;
    logic ack;
    logic rd;
    logic [6:0] addr;
    logic [7:0] regp;
    logic rs;
    logic crc_en;
    logic fast;
    logic wr_take;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic err;
    logic busy;
  } twr_host_t;

  localparam twr_host_t HOST_RST = '{
    st: H_IDLE, kind: K_AD, scl_oe_n: 1'b1, sda_oe_n: 1'b1, sda1: 1'b1, sda2: 1'b1,
    crc: `TWR_CRC_INIT, default: '0
  };

  twr_host_t s;
  twr_host_t n;
  logic rx;

  // Loads the next byte; sent address, register and data bytes join the check byte.
  function automatic twr_host_t ld(input twr_host_t x, input twr_kind_t k, input logic [7:0] b);
    twr_host_t y;
    y = x;
    y.kind = k;
    y.bcnt = '0;
    y.sh = b;
    if (k == K_AD || k == K_RA || k == K_WD) begin
      y.crc = twr_crc8(x.crc, b);
    end
    return y;
  endfunction : ld

  assign rx = (s.kind == K_RD) || (s.kind == K_RC);

  // Quarter-period sequencer: drive data, raise clock, sample, lower clock.
  always_comb begin
    n = s;
    n.wr_take = 1'b0;
    n.rd_valid = 1'b0;
    n.done = 1'b0;
    n.sda1 = bus.sda;
    n.sda2 = s.sda1;
    n.div = (s.div == 8'h00) ? (s.fast ? 8'(`TWR_QTR_FAST_CYC - 1) : 8'(`TWR_QTR_STD_CYC - 1))
                             : s.div - 8'h01;
    if (s.st == H_IDLE) begin
      n.div = 8'h00;
      n.ph = 2'h0;
      if (go) begin
        n.st = H_START;
        n.rd = rd;
        n.addr = dev_addr;
        n.regp = reg_sel;
        n.left = len;
        n.rs = rs;
        n.crc_en = crc_en;
        n.fast = fast;
        n.rdph = 1'b0;
        n.restart = 1'b0;
        n.err = 1'b0;
        n.busy = 1'b1;
        n.crc = `TWR_CRC_INIT;
      end
    end else if (s.div == 8'h00) begin
      n.ph = s.ph + 2'h1;
      unique case (s.st)
        H_START: begin
          unique case (s.ph)
            2'h0: n.sda_oe_n = 1'b1;
            2'h1: n.scl_oe_n = 1'b1;
            2'h2: n.sda_oe_n = 1'b0;
            2'h3: begin
              n.scl_oe_n = 1'b0;
              n.st = H_BIT;
              n = ld(n, K_AD, {s.addr, s.rdph});
            end
          endcase
        end
        H_BIT: begin
          unique case (s.ph)
            2'h0: begin
              if (s.bcnt != `TWR_BYTE_END) begin
                n.sda_oe_n = rx | s.sh[7];
              end else if (!rx) begin
                n.sda_oe_n = 1'b1;
              end else if (s.kind == K_RD) begin
                // Every read byte is acknowledged except the final one when check bytes are off.
                n.ack = s.crc_en || s.left != 4'h1;
                n.sda_oe_n = ~n.ack;
                n.rd_data = s.sh;
                n.rd_valid = 1'b1;
                n.crc = twr_crc8(s.crc, s.sh);
              end else begin
                n.ack = (s.sh == s.crc) && s.left != 4'h1;
                n.sda_oe_n = ~n.ack;
                n.err = s.err | (s.sh != s.crc);
                n.crc = `TWR_CRC_INIT;
              end
            end
            2'h1: n.scl_oe_n = 1'b1;
            2'h2: begin
              if (s.bcnt == `TWR_BYTE_END) begin
                if (!rx) begin
                  n.ack = ~s.sda2;
                end
              end else if (rx) begin
                n.sh = {s.sh[6:0], s.sda2};
              end else begin
                n.sh = {s.sh[6:0], 1'b0};
              end
            end
            2'h3: begin
              n.scl_oe_n = 1'b0;
              n.bcnt = s.bcnt + 4'h1;
              if (s.bcnt == `TWR_BYTE_END) begin
                n.st = H_STOP;
                if (!s.ack && !rx) begin
                  n.err = 1'b1;
                end else if (s.kind == K_AD) begin
                  n.st = H_BIT;
                  n = s.rdph ? ld(n, K_RD, 8'h00) : ld(n, K_RA, s.regp);
                end else if (s.kind == K_RA && s.rd) begin
                  n.st = s.rs ? H_START : H_STOP;
                  n.rdph = s.rs;
                  n.restart = !s.rs;
                end else if (s.kind == K_RA || (s.kind == K_WC && s.left != 4'h1)) begin
                  n.st = H_BIT;
                  n = ld(n, K_WD, wr_data);
                  n.wr_take = 1'b1;
                  n.left = (s.kind == K_WC) ? s.left - 4'h1 : s.left;
                end else if (s.kind == K_WD && s.crc_en) begin
                  n.st = H_BIT;
                  n = ld(n, K_WC, s.crc);
                  n.crc = `TWR_CRC_INIT;
                end else if (s.kind == K_WD && s.left != 4'h1) begin
                  n.st = H_BIT;
                  n = ld(n, K_WD, wr_data);
                  n.wr_take = 1'b1;
                  n.left = s.left - 4'h1;
                end else if (s.kind == K_RD && s.crc_en) begin
                  n.st = H_BIT;
                  n = ld(n, K_RC, 8'h00);
                end else if (rx && s.ack) begin
                  n.st = H_BIT;
                  n = ld(n, K_RD, 8'h00);
                  n.left = s.left - 4'h1;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (s.ph)
            2'h0: n.sda_oe_n = 1'b0;
            2'h1: n.scl_oe_n = 1'b1;
            2'h2: begin
              n.sda_oe_n = 1'b1;
              n.crc = `TWR_CRC_INIT;
            end
            2'h3: begin
              // A read without repeated start opens a fresh transfer here.
              n.restart = 1'b0;
              n.rdph = s.restart;
              n.st = s.restart ? H_START : H_IDLE;
              n.busy = s.restart;
              n.done = !s.restart;
            end
          endcase
        end
        default: begin
          n.st = H_IDLE;
        end
      endcase
    end
  end

  // State register with clock enable.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s <= HOST_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  assign wr_take = s.wr_take;
  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;
  assign busy = s.busy;
  assign done = s.done;
  assign err = s.err;
  assign bus.h_scl_o = 1'b0;
  assign bus.h_scl_oe_n = s.scl_oe_n;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_sda_oe_n = s.sda_oe_n;

endmodule : twr_controller
`default_nettype wire

// >>> twr_monitor.sv
// Wire checker for the two-wire link.
`timescale 1ns/1ps
`default_nettype none
module twr_monitor (
  input wire logic sys_clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic h_scl_oe_n, // Controller clock enable.
  input wire logic d_sda_oe_n, // Responder data enable.
  input wire logic scl, // Clock line.
  input wire logic sda // Data line.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic in_frame;
  sequence s_start; scl && $fell(sda); endsequence
  sequence s_stop; scl && $rose(sda); endsequence
  // Level run lengths; the high count saturates so a long idle cannot wrap.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'h0000;
      in_frame <= 1'b0;
    end else begin
      hi_cnt <= scl ? hi_cnt + {15'h0000, ~&hi_cnt} : 16'h0000;
      lo_cnt <= scl ? 16'h0000 : lo_cnt + 16'h0001;
      in_frame <= (scl && $fell(sda)) ? 1'b1 : ((scl && $rose(sda)) ? 1'b0 : in_frame);
    end
  end
  // Clock comes from the controller alone and never beats faster than the fast rate.
  a_clk_from_ctl: assert property (scl == h_scl_oe_n)
    else $error("clock not from controller");
  a_high_phase: assert property ($fell(scl) |-> $past(hi_cnt) >= 16'h0078)
    else $error("clock high too short");
  a_low_phase: assert property ($rose(scl) |-> $past(lo_cnt) >= 16'h0078)
    else $error("clock low too short");
  a_low_bound: assert property (!scl |-> lo_cnt < 16'h0258)
    else $error("clock low too long");
  // The responder moves its data line only while the clock is low.
  a_resp_moves_low: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("responder data moved with clock high");
  a_start_holds: assert property (s_start |-> scl [*8])
    else $error("start not held");
  a_stop_holds: assert property (s_stop |-> sda [*8])
    else $error("stop not held");
  a_quiet_idle: assert property (!in_frame |-> d_sda_oe_n)
    else $error("responder drove outside a frame");
endmodule : twr_monitor
`default_nettype wire

// >>> two_wire_responder_crc_tb_top.sv
// Bench joining controller and responder over the bus, with a register space model.
`timescale 1ns/1ps
`default_nettype none
module two_wire_responder_crc_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic go, rd, rs, crc_en, cfg_fast, cfg_upd, sw_cmd, oth_cmd, ce_h, ce_d, cfg_av, cfg_to, frz;
  logic wr_take, rd_valid, done, err, reg_we, reg_re, act, spd, busy, if_rst;
  logic [6:0] dev_addr, cfg_a, my_a;
  logic [7:0] reg_sel, wr_data, rd_data, reg_addr, reg_wdata, reg_rdata;
  logic [3:0] len;
  logic [7:0] mem [256];
  logic [7:0] wq [17];
  int exp_m [256];
  int rq [$];
  int widx, seed = 93948, n_mismatch = 0, num_checks = 0;
  always #5 sys_clk = ~sys_clk;
  twr_if bus ();
  twr_controller u_twr_controller (.sys_clk(sys_clk), .nrst(nrst), .ce(ce_h), .bus(bus),
    .go(go), .rd(rd), .dev_addr(dev_addr), .reg_sel(reg_sel), .len(len), .rs(rs),
    .crc_en(crc_en), .fast(cfg_fast), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .done(done), .err(err));
  // The fast limit sits above a normal clock-low phase of 126 cycles.
  twr_responder #(.TO_STD_CYC(300), .TO_FAST_CYC(200), .EXT_CTRL_CYC(2000),
    .EXT_RESP_CYC(5000), .TO_LONG_CYC(600)) u_twr_responder (.sys_clk(sys_clk), .nrst(nrst),
    .ce(ce_d), .bus(bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .cfg_addr_valid(cfg_av), .cfg_addr(cfg_a),
    .cfg_fast(cfg_fast), .cfg_crc_en(crc_en), .cfg_timeout_en(cfg_to), .cfg_update_mode(cfg_upd),
    .switch_to_two_wire_cmd(sw_cmd), .other_if_cmd(oth_cmd), .two_wire_active(act),
    .speed_fast(spd), .if_reset(if_rst));
  twr_monitor u_twr_monitor (.sys_clk(sys_clk), .nrst(nrst), .h_scl_oe_n(bus.h_scl_oe_n),
    .d_sda_oe_n(bus.d_sda_oe_n), .scl(bus.scl), .sda(bus.sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] want, input string what);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // Register space: writes land at the edge, read data follows one cycle later.
  always @(posedge sys_clk) begin
    if (reg_we === 1'b1) mem[reg_addr] <= reg_wdata;
    reg_rdata <= mem[reg_addr];
    if (wr_take === 1'b1) begin
      wr_data <= wq[widx + 1];
      widx <= widx + 1;
    end
    if (rd_valid === 1'b1) chk(rd_data, 8'(rq.pop_front()), "rd");
  end
  // Stall the controller once with the clock low, long enough for the fast timeout to trip.
  always @(posedge sys_clk) begin
    if (frz && bus.scl === 1'b0) begin
      frz <= 1'b0;
      ce_h <= 1'b0;
      repeat (400) @(posedge sys_clk);
      chk({7'h00, if_rst}, 8'h01, "tmo");
      ce_h <= 1'b1;
    end
  end
  // One transfer; ok says whether the address should be answered.
  task automatic xfer(input bit r, input bit rsb, input bit c, input int ra, input int n,
    input bit ok);
    int t;
    for (int i = 0; i < n; i++) begin
      wq[i] = 8'($random(seed));
      if (r && ok) rq.push_back(exp_m[(ra + i) % 256]);
    end
    rd <= r;
    rs <= rsb;
    crc_en <= c;
    reg_sel <= 8'(ra);
    len <= 4'(n);
    dev_addr <= ok ? my_a : my_a ^ 7'h01;
    wr_data <= wq[0];
    widx <= 0;
    go <= 1'b1;
    @(posedge sys_clk) go <= 1'b0;
    @(posedge sys_clk);
    chk({7'h00, busy}, 8'h01, "busy");
    t = 0;
    while (done !== 1'b1 && t < 30000) begin
      @(posedge sys_clk);
      t++;
    end
    @(posedge sys_clk);
    if (t == 30000) n_mismatch++;
    chk({7'h00, err}, {7'h00, !ok}, "err");
    chk({6'h00, busy, if_rst}, 8'h00, "idle");
    if (!r && ok) for (int i = 0; i < n; i++) exp_m[(ra + i) % 256] = wq[i];
    for (int i = 0; i <= n; i++) chk(mem[(ra + i) % 256], 8'(exp_m[(ra + i) % 256]), "mem");
    chk(8'(rq.size()), 8'h00, "cnt");
  endtask : xfer
  // Speed and interface selection, then transfers; a lost handshake is cut short.
  initial begin
    int ra;
    {go, rd, rs, crc_en, cfg_upd, sw_cmd, oth_cmd, cfg_fast} = 8'h01;
    {ce_h, ce_d, cfg_av, cfg_to, frz, cfg_a, my_a} = {5'h18, 7'h00, 7'h08};
    {dev_addr, reg_sel, len, wr_data} = 27'h0000000;
    widx = 0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($random(seed));
      exp_m[i] = mem[i];
    end
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    cfg_upd <= 1'b1;
    cfg_fast <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, spd}, 8'h01, "spd");
    // The first edge of the pulse falls while the responder is frozen and must be lost.
    ce_d <= 1'b0;
    oth_cmd <= 1'b1;
    @(posedge sys_clk) ce_d <= 1'b1;
    cfg_upd <= 1'b0;
    @(posedge sys_clk) oth_cmd <= 1'b0;
    chk({7'h00, act}, 8'h01, "hold");
    repeat (2) @(posedge sys_clk);
    chk({7'h00, spd}, 8'h00, "spd");
    chk({7'h00, act}, 8'h00, "act");
    sw_cmd <= 1'b1;
    cfg_fast <= 1'b1;
    cfg_upd <= 1'b1;
    @(posedge sys_clk) sw_cmd <= 1'b0;
    cfg_upd <= 1'b0;
    @(posedge sys_clk);
    chk({7'h00, act}, 8'h01, "act");
    ra = {$random(seed)} % 200;
    xfer(0, 0, 1, ra, 3, 1);
    xfer(1, 1, 1, ra, 3, 1);
    xfer(1, 0, 0, ra + 1, 2, 1);
    xfer(0, 0, 0, 255, 2, 1);
    // Timeouts are switched on only with the bus at the fast rate.
    frz <= 1'b1;
    cfg_to <= 1'b1;
    xfer(0, 0, 1, ra, 1, 0);
    cfg_av <= 1'b1;
    cfg_a <= 7'h09;
    my_a = 7'h09;
    xfer(1, 0, 1, 255, 2, 1);
    summarize();
  end
  // Watchdog sized above the longest expected run.
  initial begin
    #950000;
    n_mismatch++;
    summarize();
  end
endmodule : two_wire_responder_crc_tb_top
`default_nettype wire
